// *** pkg/sram_decode_pkg.sv ***
// Shared constants and types for the pipelined SRAM cycle decoder
`default_nettype none
package sram_decode_pkg;
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_BITS = 8;
  localparam int unsigned SLICE_W = 9;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 36;
  localparam int unsigned ADDR_W = 19;
  localparam int unsigned MEM_DEPTH = 524288;
  localparam int unsigned PIN_SYNC_W = 2;
  localparam int unsigned SYNC_SLEEP_BIT = 0;
  localparam int unsigned SYNC_ORDER_BIT = 1;
  localparam int unsigned LANE_COUNT_FULL = 4;
  localparam int unsigned LANE_COUNT_HALF = 2;
  localparam logic [1:0] SLEEP_ENTRY_CYCLES = 2'h2;
  localparam logic [1:0] SLEEP_EXIT_CYCLES = 2'h2;
  localparam logic [1:0] BEAT_RESET = 2'h0;
  localparam logic [1:0] SLEEP_CNT_RESET = 2'h0;
  localparam logic [1:0] PIN_RESET = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 36'h000000000;

  typedef enum logic [2:0] {
    ST_DESEL = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_SLEEP_ENTER = 3'b011,
    ST_SLEEP = 3'b100,
    ST_SLEEP_EXIT = 3'b101
  } burst_state_t;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } cycle_op_t;
endpackage
`default_nettype wire

// *** pkg/mem_port_if.sv ***
// Port between the cycle decoder and its word store
`default_nettype none
interface mem_port_if;
  import sram_decode_pkg::*;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [LANES-1:0] wr_lanes;
  logic [WORD_W-1:0] wr_data;
  modport ctrl (output rd_en, output rd_addr, input rd_data,
                output wr_en, output wr_addr, output wr_lanes, output wr_data);
  modport store (input rd_en, input rd_addr, output rd_data,
                 input wr_en, input wr_addr, input wr_lanes, input wr_data);
endinterface
`default_nettype wire

// *** hw/sram_word_store.sv ***
// Byte-lane word store with registered read data
`default_nettype none
module sram_word_store
  import sram_decode_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Access port
  mem_port_if.store port
);
  logic [WORD_W-1:0] mem [MEM_DEPTH];
  logic [WORD_W-1:0] rd_data_q;
  logic [WORD_W-1:0] rd_data_d;

  // Same-edge write is forwarded so back-to-back write then read sees new bytes
  always_comb begin
    rd_data_d = rd_data_q;
    if (port.rd_en) begin
      rd_data_d = mem[port.rd_addr];
      for (int l = 0; l < LANES; l++) begin
        if (port.wr_en && port.wr_lanes[l] && (port.wr_addr == port.rd_addr)) begin
          rd_data_d[l*SLICE_W +: SLICE_W] = port.wr_data[l*SLICE_W +: SLICE_W];
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rd_data_q <= WORD_RESET;
    end else begin
      rd_data_q <= rd_data_d;
    end
    if (port.wr_en) begin
      for (int l = 0; l < LANES; l++) begin
        if (port.wr_lanes[l]) begin
          mem[port.wr_addr][l*SLICE_W +: SLICE_W] <= port.wr_data[l*SLICE_W +: SLICE_W];
        end
      end
    end
  end

  assign port.rd_data = rd_data_q;
endmodule // sram_word_store
`default_nettype wire

// *** hw/pipelined_sram_cycle_decode.sv ***
// Command decode, burst sequencing and data bus control of a pipelined burst SRAM
// Function
// - Load edge with a chip select inactive deselects; continue edges keep it deselected.
// - All selects active, load, write strobe high starts a read burst.
// - Continue edge in a read burst reads the next burst address.
// - Read with output enable high runs internally but leaves the bus undriven.
// - Selected load with strobe low and a lane select low starts a write.
// - Continue edge in a write burst writes next address with that beat's lanes.
// - Write start with all lane selects high is an abort: nothing used or written.
// - Write continue with all lane selects high advances without changing bytes.
// - Clock qualifier high makes the edge ignored by command decode; sleep entry and exit still advance.
// - A write cycle releases every data and parity line.
// - Output enable acts combinationally on drivers and is masked during writes.
// - Bus carries read data only when enabled, selected and in a read.
// - After reset the device is deselected with the bus released.
// - Direction comes from the strobe; strobe high means read regardless of lanes.
// - Each active lane writes its byte and parity; other lanes stay unchanged.
// - Four-lane build: lanes a to d each follow their own select.
// - Two-lane build: lanes a and b only; both selects high writes nothing.
// - Sleep overrides all, releases the bus, two cycles to enter and to leave.
// - Burst order input picks linear or interleaved on the two low address bits.
// - Direction is held from burst start for every beat.
// - Write data is captured on the second qualified edge after its command.
`default_nettype none
module pipelined_sram_cycle_decode
  import sram_decode_pkg::*;
#(
  parameter int unsigned LANE_COUNT = LANE_COUNT_FULL
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Synchronous command pins
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic chip_select_1_n_in,
  input wire logic chip_select_2_in,
  input wire logic chip_select_3_n_in,
  input wire logic advance_load_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [LANES-1:0] byte_lane_select_n_in,
  input wire logic clock_qualify_n_in,
  // Static and asynchronous pins
  input wire logic burst_order_in,
  input wire logic sleep_request_in,
  input wire logic output_enable_n_in,
  // Shared data bus
  input wire logic [DATA_W-1:0] data_lines_in,
  input wire logic [LANES-1:0] parity_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic [LANES-1:0] parity_lines_out,
  output logic data_lines_oe_out,
  // Status
  output logic device_asleep_out
);
  mem_port_if mem_bus ();

  // Pin synchronisers for sleep and burst order
  logic [PIN_SYNC_W-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_level_q;
  logic [PIN_SYNC_W-1:0] pin_level_d;

  // Burst and pipeline state
  burst_state_t state_q, state_d;
  logic [ADDR_W-1:0] base_q, base_d;
  logic [1:0] beat_q, beat_d;
  logic [1:0] sleep_cnt_q, sleep_cnt_d;
  cycle_op_t s1_op_q, s1_op_d, s2_op_q, s2_op_d;
  logic [ADDR_W-1:0] s1_addr_q, s1_addr_d, s2_addr_q, s2_addr_d;
  logic [LANES-1:0] s1_lanes_q, s1_lanes_d, s2_lanes_q, s2_lanes_d;

  logic sleep_level;
  logic order_level;
  logic awake;
  logic advance;
  logic all_selected;
  logic [LANES-1:0] lane_mask;
  logic [LANES-1:0] lanes_active;
  logic [1:0] beat_next;
  logic [1:0] low_next;
  logic [ADDR_W-1:0] addr_next;
  logic [WORD_W-1:0] wr_word;

  // Three-stage pin capture; level moves only when stages two and three agree
  always_comb begin
    pin_level_d = pin_level_q;
    for (int b = 0; b < PIN_SYNC_W; b++) begin
      if (pin_s2_q[b] == pin_s3_q[b]) begin
        pin_level_d[b] = pin_s3_q[b];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pin_s1_q <= PIN_RESET;
      pin_s2_q <= PIN_RESET;
      pin_s3_q <= PIN_RESET;
      pin_level_q <= PIN_RESET;
    end else begin
      pin_s1_q <= {burst_order_in, sleep_request_in};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_level_q <= pin_level_d;
    end
  end

  assign sleep_level = pin_level_q[SYNC_SLEEP_BIT];
  assign order_level = pin_level_q[SYNC_ORDER_BIT];

  // Lanes beyond the build's count never write
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      lane_mask[l] = (l < LANE_COUNT);
    end
  end

  assign lanes_active = ~byte_lane_select_n_in & lane_mask;
  assign all_selected = ~chip_select_1_n_in & chip_select_2_in & ~chip_select_3_n_in;
  assign awake = (state_q == ST_DESEL) || (state_q == ST_READ) || (state_q == ST_WRITE);
  assign advance = awake && !sleep_level && !clock_qualify_n_in;

  // Burst sequence only touches the two low address bits and wraps
  assign beat_next = beat_q + 2'h1;
  assign low_next = order_level ? (base_q[1:0] ^ beat_next)
                                : (base_q[1:0] + beat_next);
  assign addr_next = {base_q[ADDR_W-1:2], low_next};

  always_comb begin
    state_d = state_q;
    base_d = base_q;
    beat_d = beat_q;
    sleep_cnt_d = sleep_cnt_q;
    s1_op_d = s1_op_q;
    s1_addr_d = s1_addr_q;
    s1_lanes_d = s1_lanes_q;
    s2_op_d = s2_op_q;
    s2_addr_d = s2_addr_q;
    s2_lanes_d = s2_lanes_q;
    case (state_q)
      ST_DESEL, ST_READ, ST_WRITE: begin
        if (sleep_level) begin
          // Pending accesses are dropped; sleep wins over every pin
          state_d = ST_SLEEP_ENTER;
          sleep_cnt_d = SLEEP_CNT_RESET;
          s1_op_d = OP_NONE;
          s2_op_d = OP_NONE;
        end else if (advance) begin
          s2_op_d = s1_op_q;
          s2_addr_d = s1_addr_q;
          s2_lanes_d = s1_lanes_q;
          s1_op_d = OP_NONE;
          s1_lanes_d = LANES_NONE;
          if (!advance_load_n_in) begin
            if (!all_selected) begin
              state_d = ST_DESEL;
            end else if (write_strobe_n_in) begin
              state_d = ST_READ;
              base_d = address_in;
              beat_d = BEAT_RESET;
              s1_op_d = OP_READ;
              s1_addr_d = address_in;
            end else if (|lanes_active) begin
              state_d = ST_WRITE;
              base_d = address_in;
              beat_d = BEAT_RESET;
              s1_op_d = OP_WRITE;
              s1_addr_d = address_in;
              s1_lanes_d = lanes_active;
            end else begin
              state_d = ST_DESEL;
            end
          end else begin
            case (state_q)
              ST_READ: begin
                beat_d = beat_next;
                s1_op_d = OP_READ;
                s1_addr_d = addr_next;
              end
              ST_WRITE: begin
                // Lanes may be all inactive: address moves, no byte changes
                beat_d = beat_next;
                s1_op_d = OP_WRITE;
                s1_addr_d = addr_next;
                s1_lanes_d = lanes_active;
              end
              default: begin
                s1_op_d = OP_NONE;
              end
            endcase
          end
        end
      end
      ST_SLEEP_ENTER: begin
        sleep_cnt_d = sleep_cnt_q + 2'h1;
        if (sleep_cnt_d == SLEEP_ENTRY_CYCLES) begin
          state_d = ST_SLEEP;
          sleep_cnt_d = SLEEP_CNT_RESET;
        end
      end
      ST_SLEEP: begin
        if (!sleep_level) begin
          state_d = ST_SLEEP_EXIT;
          sleep_cnt_d = SLEEP_CNT_RESET;
        end
      end
      ST_SLEEP_EXIT: begin
        sleep_cnt_d = sleep_cnt_q + 2'h1;
        if (sleep_level) begin
          state_d = ST_SLEEP_ENTER;
          sleep_cnt_d = SLEEP_CNT_RESET;
        end else if (sleep_cnt_d == SLEEP_EXIT_CYCLES) begin
          state_d = ST_DESEL;
          sleep_cnt_d = SLEEP_CNT_RESET;
        end
      end
      default: begin
        state_d = ST_DESEL;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q <= ST_DESEL;
      base_q <= ADDR_RESET;
      beat_q <= BEAT_RESET;
      sleep_cnt_q <= SLEEP_CNT_RESET;
      s1_op_q <= OP_NONE;
      s1_addr_q <= ADDR_RESET;
      s1_lanes_q <= LANES_NONE;
      s2_op_q <= OP_NONE;
      s2_addr_q <= ADDR_RESET;
      s2_lanes_q <= LANES_NONE;
    end else begin
      state_q <= state_d;
      base_q <= base_d;
      beat_q <= beat_d;
      sleep_cnt_q <= sleep_cnt_d;
      s1_op_q <= s1_op_d;
      s1_addr_q <= s1_addr_d;
      s1_lanes_q <= s1_lanes_d;
      s2_op_q <= s2_op_d;
      s2_addr_q <= s2_addr_d;
      s2_lanes_q <= s2_lanes_d;
    end
  end

  // Pack pin lanes as {parity, byte} slices for the store
  always_comb begin
    wr_word = WORD_RESET;
    for (int l = 0; l < LANES; l++) begin
      wr_word[l*SLICE_W +: SLICE_W] = {parity_lines_in[l], data_lines_in[l*LANE_BITS +: LANE_BITS]};
    end
  end

  // Read is issued one edge after the command so data lands after the second
  assign mem_bus.rd_en = advance && (s1_op_q == OP_READ);
  assign mem_bus.rd_addr = s1_addr_q;
  assign mem_bus.wr_en = advance && (s2_op_q == OP_WRITE) && (|s2_lanes_q);
  assign mem_bus.wr_addr = s2_addr_q;
  assign mem_bus.wr_lanes = s2_lanes_q;
  assign mem_bus.wr_data = wr_word;

  sram_word_store u_store (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .port(mem_bus.store)
  );

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      data_lines_out[l*LANE_BITS +: LANE_BITS] = mem_bus.rd_data[l*SLICE_W +: LANE_BITS];
      parity_lines_out[l] = mem_bus.rd_data[l*SLICE_W + LANE_BITS];
    end
  end

  // Output enable is not sampled; a write or deselect in the data stage masks it
  assign data_lines_oe_out = awake && !sleep_level && (s2_op_q == OP_READ)
                             && !output_enable_n_in;
  assign device_asleep_out = (state_q == ST_SLEEP);
endmodule // pipelined_sram_cycle_decode
`default_nettype wire

// *** verif/sram_decode_properties.sv ***
// Port-level timing properties of the SRAM cycle decoder
`default_nettype none
module sram_decode_properties
  import sram_decode_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Command pins
  input wire logic chip_select_1_n_in,
  input wire logic chip_select_2_in,
  input wire logic chip_select_3_n_in,
  input wire logic advance_load_n_in,
  input wire logic write_strobe_n_in,
  input wire logic clock_qualify_n_in,
  input wire logic sleep_request_in,
  input wire logic output_enable_n_in,
  // Device outputs
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe_out,
  input wire logic device_asleep_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel;
  logic run;
  assign sel = !chip_select_1_n_in && chip_select_2_in && !chip_select_3_n_in;
  assign run = !clock_qualify_n_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_oe_needs_pin: assert property (data_lines_oe_out |-> !output_enable_n_in)
    else $error("bus driven with output enable off");
  a_asleep_quiet: assert property (device_asleep_out |-> !data_lines_oe_out)
    else $error("bus driven while asleep");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst_in |=> !data_lines_oe_out && !device_asleep_out)
    else $error("not released after reset");
  a_stall_holds: assert property (
    !run && !device_asleep_out |=> $stable(data_lines_out))
    else $error("read data moved on a stalled edge");
  // Data stage follows the load by one qualified edge, so a later load cannot leak in
  a_deselect_quiet: assert property (
    run && !advance_load_n_in && chip_select_1_n_in ##1 run && advance_load_n_in
    |=> !data_lines_oe_out [*2])
    else $error("bus driven after deselect");
  a_write_masks_oe: assert property (
    run && !advance_load_n_in && sel && !write_strobe_n_in ##1 run && advance_load_n_in
    |=> !data_lines_oe_out [*2])
    else $error("bus driven during write");
  a_read_drives: assert property (
    run && !advance_load_n_in && sel && write_strobe_n_in ##1 run && advance_load_n_in
    ##1 run && advance_load_n_in |=> data_lines_oe_out == !output_enable_n_in)
    else $error("read burst not driven");
  a_sleep_entry: assert property (sleep_request_in [*8] |-> device_asleep_out)
    else $error("sleep not entered in time");
  a_wake_bounded: assert property (
    $fell(sleep_request_in) |-> ##[1:8] !device_asleep_out)
    else $error("sleep not left in time");
endmodule // sram_decode_properties
bind pipelined_sram_cycle_decode sram_decode_properties sram_decode_properties_i (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .chip_select_1_n_in(chip_select_1_n_in),
  .chip_select_2_in(chip_select_2_in), .chip_select_3_n_in(chip_select_3_n_in),
  .advance_load_n_in(advance_load_n_in), .write_strobe_n_in(write_strobe_n_in),
  .clock_qualify_n_in(clock_qualify_n_in), .sleep_request_in(sleep_request_in),
  .output_enable_n_in(output_enable_n_in), .data_lines_out(data_lines_out),
  .data_lines_oe_out(data_lines_oe_out), .device_asleep_out(device_asleep_out));
`default_nettype wire

// *** verif/sram_ctrl_bus_model.sv ***
// Controller side of the shared data and parity lines
`default_nettype none
module sram_ctrl_bus_model
  import sram_decode_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Drivers of both parties
  input wire logic dev_oe_in,
  input wire logic [WORD_W-1:0] dev_word_in,
  input wire logic drv_en_in,
  input wire logic [WORD_W-1:0] drv_word_in,
  // Resolved lines
  output logic [WORD_W-1:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] last_q = WORD_RESET;
  always_comb begin
    if (drv_en_in) begin
      bus_out = drv_word_in;
    end else if (dev_oe_in) begin
      bus_out = dev_word_in;
    end else begin
      // Released lines never repeat the last value
      bus_out = ~last_q;
    end
  end
  always_ff @(posedge clock_in) begin
    last_q <= bus_out;
  end
endmodule // sram_ctrl_bus_model
`default_nettype wire

// *** verif/test_pipelined_sram_cycle_decode.sv ***
// Self-checking bench for the pipelined SRAM cycle decoder
`default_nettype none
module test_pipelined_sram_cycle_decode
  import sram_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {cycle_op_t op; logic [3:0] a; logic [3:0] ln;} slot_t;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, cs1_n = 1'b1, cs2 = 1'b0, cs3_n = 1'b1;
  logic adv_n = 1'b0, we_n = 1'b1, cq_n = 1'b0, order = 1'b0, sleep = 1'b0;
  logic oe_n = 1'b1, drv_en = 1'b0, oe_out, asleep;
  logic [3:0] ln_n = 4'hF;
  logic [ADDR_W-1:0] addr = 19'h00000;
  logic [WORD_W-1:0] drv_w = 36'h000000000;
  logic [WORD_W-1:0] bus_w;
  logic [WORD_W-1:0] mem [16];
  logic [DATA_W-1:0] dq;
  logic [LANES-1:0] parity_lines;
  slot_t s1 = '0, s2 = '0;
  cycle_op_t mode = OP_NONE;
  logic [3:0] base = 4'h0;
  logic [1:0] beat = 2'h0;
  integer seed = 57, err_total = 0, num_checks = 0, n;
  always #50 clock_in = ~clock_in;
  pipelined_sram_cycle_decode pipelined_sram_cycle_decode_i (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .address_in(addr),
    .chip_select_1_n_in(cs1_n), .chip_select_2_in(cs2), .chip_select_3_n_in(cs3_n),
    .advance_load_n_in(adv_n), .write_strobe_n_in(we_n), .byte_lane_select_n_in(ln_n),
    .clock_qualify_n_in(cq_n), .burst_order_in(order), .sleep_request_in(sleep),
    .output_enable_n_in(oe_n), .data_lines_in(bus_w[31:0]), .parity_lines_in(bus_w[35:32]),
    .data_lines_out(dq), .parity_lines_out(parity_lines), .data_lines_oe_out(oe_out),
    .device_asleep_out(asleep));
  sram_ctrl_bus_model sram_ctrl_bus_model_i (.clock_in(clock_in), .dev_oe_in(oe_out),
    .dev_word_in({parity_lines, dq}), .drv_en_in(drv_en), .drv_word_in(drv_w), .bus_out(bus_w));
  function automatic logic [3:0] beat_addr(input logic [3:0] b, input logic [1:0] k);
    beat_addr = {b[3:2], order ? b[1:0] ^ k : b[1:0] + k};
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_oe(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Reference pipeline: command stage, then data stage
  task automatic model_edge();
    slot_t nw;
    if (cq_n)
      return;
    if (s2.op == OP_WRITE)
      for (int l = 0; l < 4; l++) begin
        if (s2.ln[l]) begin
          mem[s2.a][l*8 +: 8] = drv_w[l*8 +: 8];
          mem[s2.a][32+l] = drv_w[32+l];
        end
      end
    if (!adv_n) begin
      beat = 2'h0;
      base = addr[3:0];
      mode = OP_NONE;
      if (!cs1_n && cs2 && !cs3_n)
        mode = we_n ? OP_READ
                    : (ln_n == 4'hF ? OP_NONE : OP_WRITE);
    end else if (mode != OP_NONE) begin
      beat = beat + 2'h1;
    end
    nw.op = mode;
    nw.a = beat_addr(base, beat);
    nw.ln = ~ln_n;
    s2 = s1;
    s1 = nw;
  endtask
  task automatic step(input logic st, ld, w, input logic [3:0] a, l, input logic [2:0] cs);
    logic [31:0] r;
    logic [31:0] q;
    @(posedge clock_in);
    model_edge();
    #10;
    r = $random(seed);
    q = $random(seed);
    {cs1_n, cs2, cs3_n} = cs;
    cq_n = st;
    adv_n = ld;
    we_n = w;
    addr = {15'h0000, a};
    ln_n = l;
    oe_n = r[0];
    drv_en = s2.op == OP_WRITE;
    drv_w = {r[4:1], q};
    #40;
    // Read data registers on the first qualified edge after the command
    cmp_oe(oe_out, s2.op == OP_READ && !oe_n);
    if (s2.op == OP_READ)
      cmp({parity_lines, dq}, mem[s2.a]);
  endtask
  task automatic rand_step();
    logic [31:0] r;
    r = $random(seed);
    step(r[2:0] == 3'h0, r[3], r[4], r[8:5], r[12:9],
         (r[14:13] == 2'h0 && r[17:15] != 3'h0) ? r[17:15] ^ 3'h2 : 3'h2);
  endtask
  task automatic wait_asleep(input logic lv);
    for (int i = 0; i < 20 && asleep !== lv; i++) begin
      @(posedge clock_in);
      #50;
      cmp_oe(oe_out, 1'b0);
    end
    if (asleep !== lv) begin
      err_total++;
      finish_test();
    end
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    #10;
    sys_rst_in = 1'b0;
    cmp_oe(oe_out, 1'b0);
    for (n = 0; n < 16; n++)
      step(1'b0, n[1:0] != 2'h0, 1'b0, n[3:0], 4'h0, 3'h2);
    for (n = 0; n < 16; n++)
      step(1'b0, 1'b0, 1'b0, n[3:0], n[3:0], 3'h2);
    step(1'b0, 1'b0, 1'b0, 4'h5, 4'h3, 3'h2);
    step(1'b0, 1'b1, 1'b0, 4'h0, 4'hF, 3'h2);
    order = 1'b1;
    for (n = 0; n < 24; n++)
      step(1'b0, n >= 8 && n[1:0] != 2'h0, 1'b1, n[3:0], 4'h0, n < 8 ? 3'h7 : 3'h2);
    for (n = 0; n < 700; n++)
      rand_step();
    for (n = 0; n < 4; n++)
      step(1'b0, 1'b0, 1'b1, 4'h0, 4'h0, 3'h7);
    // Pipeline is empty here, so one unmodelled deselect edge is harmless
    @(posedge clock_in);
    #10;
    sleep = 1'b1;
    order = 1'b0;
    wait_asleep(1'b1);
    repeat (8) @(posedge clock_in);
    #10;
    sleep = 1'b0;
    wait_asleep(1'b0);
    for (n = 0; n < 6; n++)
      step(1'b0, 1'b0, 1'b1, 4'h0, 4'h0, 3'h7);
    for (n = 0; n < 700; n++)
      rand_step();
    finish_test();
  end
endmodule // test_pipelined_sram_cycle_decode
`default_nettype wire
